// ===== design/beta_cfg_pkg.sv
package beta_cfg_pkg;

   // Register offsets on the two-wire port.
   localparam logic [7:0] IDEALITY_FACTOR_SELECT_OFS = 8'h14;
   localparam logic [7:0] IDEALITY_CUSTOM_ENABLE_OFS = 8'h15;
   localparam logic [7:0] BETA_COMP_ENABLE_OFS       = 8'h19;
   localparam logic [7:0] BETA_RESULT_CH1_OFS        = 8'h1A;
   localparam logic [7:0] BETA_RESULT_CH2_OFS        = 8'h1B;
   localparam logic [7:0] BETA_RESULT_CH3_OFS        = 8'h1C;
   localparam logic [7:0] DIODE_FAULT_STATUS_OFS     = 8'h36;

   // Reset values.
   localparam logic [7:0] IDEALITY_CODE_RESET = 8'h18;
   localparam logic [7:0] CHAN_BITS_RESET     = 8'h00;
   localparam logic [3:0] BETA_RESULT_RESET   = 4'h0;
   localparam logic [7:0] READ_UNMAPPED       = 8'h00;

   // Per-channel bit field: channels 3..1 sit at bits 3..1.
   localparam int unsigned CHAN_LSB = 1;
   localparam int unsigned CHAN_MSB = 3;
   localparam logic [7:0]  CHAN_MASK = 8'h0E;

   // Ideality decode, in units of 0.0001.
   localparam logic [7:0]  IDEALITY_UNITY_CODE  = 8'h10;
   localparam logic [7:0]  IDEALITY_LAST_VALID  = 8'h3F;
   localparam logic [15:0] IDEALITY_UNITY_VALUE = 16'h2710;
   localparam logic [15:0] IDEALITY_STEP        = 16'h000A;
   localparam logic [15:0] IDEALITY_DEFAULT     = 16'h2760;

   // Beta result codes; codes above the last valid one mean beta under 0.09.
   localparam logic [3:0] BETA_LAST_VALID_CODE = 4'h9;
   localparam logic [3:0] DRIVE_NOMINAL        = 4'h0;

   localparam logic [15:0] TEMP_FAULT_VALUE = 16'h0000;
   localparam logic [1:0]  CHAN_NONE        = 2'h0;

   // Two-wire port framing.
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h4C;

endpackage

// ===== design/twowire_slave.sv
`timescale 1ns/100ps
module twowire_slave
   import beta_cfg_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
)(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   output logic            reg_wr,
   output logic            reg_rd_done,
   output logic [7:0]      reg_ptr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);

   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK, S_WDATA, S_WDATA_ACK, S_RDATA, S_RDATA_ACK
   } bus_state_t;

   logic       scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
   bus_state_t st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wdata_q, wdata_d;
   logic       rw_q, rw_d, oe_q, oe_d, wr_q, wr_d, rdd_q, rdd_d, mack_q, mack_d;
   logic       scl_rise, scl_fall, start_cond, stop_cond;

   // Pins are asynchronous; edges are taken only from the second and third stages.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_s3_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_s3_q <= 1'b1;
      end
      else
      begin
         scl_s1_q <= scl_in;
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
         sda_s1_q <= sda_in;
         sda_s2_q <= sda_s1_q;
         sda_s3_q <= sda_s2_q;
      end
   end

   assign scl_rise   = scl_s2_q & ~scl_s3_q;
   assign scl_fall   = ~scl_s2_q & scl_s3_q;
   assign start_cond = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
   assign stop_cond  = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

   always_comb
   begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      sh_d    = sh_q;
      ptr_d   = ptr_q;
      wdata_d = wdata_q;
      rw_d    = rw_q;
      oe_d    = oe_q;
      mack_d  = mack_q;
      wr_d    = 1'b0;
      rdd_d   = 1'b0;
      if (start_cond)
      begin
         st_d  = S_ADDR;
         cnt_d = '0;
         oe_d  = 1'b0;
      end
      else if (stop_cond)
      begin
         st_d = S_IDLE;
         oe_d = 1'b0;
      end
      else if (scl_rise)
      begin
         if (st_q == S_ADDR || st_q == S_CMD || st_q == S_WDATA)
         begin
            sh_d  = {sh_q[6:0], sda_s2_q};
            cnt_d = cnt_q + 4'h1;
         end
         else if (st_q == S_RDATA)
            cnt_d = cnt_q + 4'h1;
         else if (st_q == S_RDATA_ACK)
         begin
            // A byte counts as read once its acknowledge slot is clocked.
            mack_d = ~sda_s2_q;
            rdd_d  = 1'b1;
         end
      end
      else if (scl_fall)
      begin
         unique case (st_q)
            S_IDLE: ;
            S_ADDR:
               if (cnt_q == BITS_PER_BYTE)
               begin
                  if (sh_q[7:1] == SLAVE_ADDR)
                  begin
                     rw_d = sh_q[0];
                     oe_d = 1'b1;
                     st_d = S_ADDR_ACK;
                  end
                  else
                     st_d = S_IDLE;
               end
            S_ADDR_ACK:
            begin
               cnt_d = '0;
               if (rw_q)
               begin
                  sh_d = reg_rdata;
                  oe_d = ~reg_rdata[7];
                  st_d = S_RDATA;
               end
               else
               begin
                  oe_d = 1'b0;
                  st_d = S_CMD;
               end
            end
            S_CMD:
               if (cnt_q == BITS_PER_BYTE)
               begin
                  ptr_d = sh_q;
                  oe_d  = 1'b1;
                  st_d  = S_CMD_ACK;
               end
            S_CMD_ACK, S_WDATA_ACK:
            begin
               oe_d  = 1'b0;
               cnt_d = '0;
               st_d  = S_WDATA;
            end
            S_WDATA:
               if (cnt_q == BITS_PER_BYTE)
               begin
                  wdata_d = sh_q;
                  wr_d    = 1'b1;
                  oe_d    = 1'b1;
                  st_d    = S_WDATA_ACK;
               end
            S_RDATA:
               if (cnt_q == BITS_PER_BYTE)
               begin
                  oe_d = 1'b0;
                  st_d = S_RDATA_ACK;
               end
               else
               begin
                  sh_d = {sh_q[6:0], 1'b0};
                  oe_d = ~sh_q[6];
               end
            S_RDATA_ACK:
            begin
               cnt_d = '0;
               if (mack_q)
               begin
                  sh_d = reg_rdata;
                  oe_d = ~reg_rdata[7];
                  st_d = S_RDATA;
               end
               else
                  st_d = S_IDLE;
            end
            default:
               st_d = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_q    <= S_IDLE;
         cnt_q   <= '0;
         sh_q    <= '0;
         ptr_q   <= '0;
         wdata_q <= '0;
         rw_q    <= 1'b0;
         oe_q    <= 1'b0;
         wr_q    <= 1'b0;
         rdd_q   <= 1'b0;
         mack_q  <= 1'b0;
      end
      else
      begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
         ptr_q   <= ptr_d;
         wdata_q <= wdata_d;
         rw_q    <= rw_d;
         oe_q    <= oe_d;
         wr_q    <= wr_d;
         rdd_q   <= rdd_d;
         mack_q  <= mack_d;
      end
   end

   // Open drain: the pin is only ever pulled low.
   assign sda_out     = 1'b0;
   assign sda_oe      = oe_q;
   assign reg_wr      = wr_q;
   assign reg_rd_done = rdd_q;
   assign reg_ptr     = ptr_q;
   assign reg_wdata   = wdata_q;

endmodule // twowire_slave

// ===== design/remote_diode_ideality_beta_config.sv
`timescale 1ns/100ps

module remote_diode_ideality_beta_config
   import beta_cfg_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
)(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        slot_start,
   input  wire logic [1:0]  slot_chan,
   input  wire logic        diode_fault_detect,
   input  wire logic        beta_done,
   input  wire logic [3:0]  beta_code,
   input  wire logic        conv_done,
   input  wire logic [15:0] conv_result,
   output logic             slot_busy,
   output logic             beta_meas_req,
   output logic             temp_meas_start,
   output logic [15:0]      slot_ideality,
   output logic [3:0]       drive_level,
   output logic             temp_wr,
   output logic [1:0]       temp_wr_chan,
   output logic [15:0]      temp_wr_data
);
   import beta_cfg_pkg::*;

   typedef enum logic [1:0] {
      SLOT_IDLE, SLOT_BETA, SLOT_MEAS
   } slot_state_t;

   logic        reg_wr, reg_rd_done;
   logic [7:0]  reg_ptr, reg_wdata, reg_rdata;

   logic [7:0]  ideal_code_q, ideal_code_d;
   logic [7:0]  ideal_en_q, ideal_en_d;
   logic [7:0]  beta_en_q, beta_en_d;
   logic [3:0]  beta_res_q [CHAN_LSB:CHAN_MSB];
   logic [3:0]  beta_res_d [CHAN_LSB:CHAN_MSB];
   logic [7:0]  fault_q, fault_d;

   slot_state_t st_q, st_d;
   logic [1:0]  chan_q, chan_d;
   logic        busy_q, busy_d, breq_q, breq_d, mstart_q, mstart_d;
   logic [15:0] ideal_q, ideal_d, twdata_q, twdata_d;
   logic [3:0]  drive_q, drive_d;
   logic        twr_q, twr_d;
   logic [1:0]  twchan_q, twchan_d;
   logic        fault_set;
   logic [1:0]  fault_chan;

   twowire_slave #(
      .SLAVE_ADDR (SLAVE_ADDR)
   ) u_port (
      .clk         (clk),
      .rst_b       (rst_b),
      .scl_in      (scl_in),
      .sda_in      (sda_in),
      .sda_out     (sda_out),
      .sda_oe      (sda_oe),
      .reg_wr      (reg_wr),
      .reg_rd_done (reg_rd_done),
      .reg_ptr     (reg_ptr),
      .reg_wdata   (reg_wdata),
      .reg_rdata   (reg_rdata)
   );

   // Codes beyond the table are not valid; the default ideality is used for them instead.
   function automatic logic [15:0] ideality_of(input logic [7:0] code);
      logic [15:0] delta;
      delta = 16'(code) * IDEALITY_STEP - 16'(IDEALITY_UNITY_CODE) * IDEALITY_STEP;
      if (code > IDEALITY_LAST_VALID)
         ideality_of = IDEALITY_DEFAULT;
      else
         ideality_of = IDEALITY_UNITY_VALUE + delta;
   endfunction

   function automatic logic [7:0] beta_reg_ofs(input int unsigned ch);
      beta_reg_ofs = BETA_RESULT_CH1_OFS + 8'(ch - CHAN_LSB);
   endfunction

   // Register read mux; reserved bits and unmapped offsets read zero.
   always_comb
   begin
      reg_rdata = READ_UNMAPPED;
      if (reg_ptr == IDEALITY_FACTOR_SELECT_OFS)
         reg_rdata = ideal_code_q;
      else if (reg_ptr == IDEALITY_CUSTOM_ENABLE_OFS)
         reg_rdata = ideal_en_q;
      else if (reg_ptr == BETA_COMP_ENABLE_OFS)
         reg_rdata = beta_en_q;
      else if (reg_ptr == DIODE_FAULT_STATUS_OFS)
         reg_rdata = fault_q;
      for (int unsigned ch = CHAN_LSB; ch <= CHAN_MSB; ch++)
         if (reg_ptr == beta_reg_ofs(ch))
            reg_rdata = {4'h0, beta_res_q[ch]};
   end

   // Software-visible registers.
   always_comb
   begin
      ideal_code_d = ideal_code_q;
      ideal_en_d   = ideal_en_q;
      beta_en_d    = beta_en_q;
      fault_d      = fault_q;
      if (reg_wr && reg_ptr == IDEALITY_FACTOR_SELECT_OFS)
         ideal_code_d = reg_wdata;
      if (reg_wr && reg_ptr == IDEALITY_CUSTOM_ENABLE_OFS)
         ideal_en_d = reg_wdata & CHAN_MASK;
      if (reg_wr && reg_ptr == BETA_COMP_ENABLE_OFS)
         beta_en_d = reg_wdata & CHAN_MASK;
      if (reg_rd_done && reg_ptr == DIODE_FAULT_STATUS_OFS)
         fault_d = CHAN_BITS_RESET;
      // A fault arriving in the same cycle as the clearing read is kept.
      if (fault_set)
         fault_d[fault_chan] = 1'b1;
   end

   // Conversion slot sequencing.
   always_comb
   begin
      st_d       = st_q;
      chan_d     = chan_q;
      busy_d     = busy_q;
      ideal_d    = ideal_q;
      drive_d    = drive_q;
      breq_d     = 1'b0;
      mstart_d   = 1'b0;
      twr_d      = 1'b0;
      twchan_d   = twchan_q;
      twdata_d   = twdata_q;
      fault_set  = 1'b0;
      fault_chan = chan_q;
      for (int unsigned ch = CHAN_LSB; ch <= CHAN_MSB; ch++)
         beta_res_d[ch] = beta_res_q[ch];
      unique case (st_q)
         SLOT_IDLE:
            if (slot_start && slot_chan != CHAN_NONE)
            begin
               // Settings are frozen here, so later writes reach only the next slot.
               chan_d  = slot_chan;
               busy_d  = 1'b1;
               ideal_d = ideal_en_q[slot_chan] ? ideality_of(ideal_code_q) : IDEALITY_DEFAULT;
               if (beta_en_q[slot_chan])
               begin
                  breq_d = 1'b1;
                  st_d   = SLOT_BETA;
               end
               else
               begin
                  // With compensation off the measurement is tried whatever the beta.
                  drive_d  = DRIVE_NOMINAL;
                  mstart_d = 1'b1;
                  st_d     = SLOT_MEAS;
               end
            end
         SLOT_BETA:
            if (diode_fault_detect || (beta_done && beta_code > BETA_LAST_VALID_CODE))
            begin
               if (beta_done)
                  beta_res_d[chan_q] = beta_code;
               fault_set = 1'b1;
               twr_d     = 1'b1;
               twchan_d  = chan_q;
               twdata_d  = TEMP_FAULT_VALUE;
               busy_d    = 1'b0;
               st_d      = SLOT_IDLE;
            end
            else if (beta_done)
            begin
               beta_res_d[chan_q] = beta_code;
               drive_d            = beta_code;
               mstart_d           = 1'b1;
               st_d               = SLOT_MEAS;
            end
         SLOT_MEAS:
            if (diode_fault_detect || conv_done)
            begin
               // Stored temperature changes only when the slot completes.
               fault_set = diode_fault_detect;
               twr_d     = 1'b1;
               twchan_d  = chan_q;
               twdata_d  = diode_fault_detect ? TEMP_FAULT_VALUE : conv_result;
               busy_d    = 1'b0;
               st_d      = SLOT_IDLE;
            end
         default:
            st_d = SLOT_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ideal_code_q <= IDEALITY_CODE_RESET;
         ideal_en_q   <= CHAN_BITS_RESET;
         beta_en_q    <= CHAN_BITS_RESET;
         fault_q      <= CHAN_BITS_RESET;
         for (int unsigned ch = CHAN_LSB; ch <= CHAN_MSB; ch++)
            beta_res_q[ch] <= BETA_RESULT_RESET;
         st_q     <= SLOT_IDLE;
         chan_q   <= CHAN_NONE;
         busy_q   <= 1'b0;
         ideal_q  <= IDEALITY_DEFAULT;
         drive_q  <= DRIVE_NOMINAL;
         breq_q   <= 1'b0;
         mstart_q <= 1'b0;
         twr_q    <= 1'b0;
         twchan_q <= CHAN_NONE;
         twdata_q <= TEMP_FAULT_VALUE;
      end
      else
      begin
         ideal_code_q <= ideal_code_d;
         ideal_en_q   <= ideal_en_d;
         beta_en_q    <= beta_en_d;
         fault_q      <= fault_d;
         for (int unsigned ch = CHAN_LSB; ch <= CHAN_MSB; ch++)
            beta_res_q[ch] <= beta_res_d[ch];
         st_q     <= st_d;
         chan_q   <= chan_d;
         busy_q   <= busy_d;
         ideal_q  <= ideal_d;
         drive_q  <= drive_d;
         breq_q   <= breq_d;
         mstart_q <= mstart_d;
         twr_q    <= twr_d;
         twchan_q <= twchan_d;
         twdata_q <= twdata_d;
      end
   end

   assign slot_busy       = busy_q;
   assign beta_meas_req   = breq_q;
   assign temp_meas_start = mstart_q;
   assign slot_ideality   = ideal_q;
   assign drive_level     = drive_q;
   assign temp_wr         = twr_q;
   assign temp_wr_chan    = twchan_q;
   assign temp_wr_data    = twdata_q;

endmodule // remote_diode_ideality_beta_config

// ===== test/slot_checker_assertions.sv
`timescale 1ns/100ps
module slot_checker (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        slot_start,
   input wire logic [1:0]  slot_chan,
   input wire logic        diode_fault_detect,
   input wire logic        beta_done,
   input wire logic [3:0]  beta_code,
   input wire logic        conv_done,
   input wire logic [15:0] conv_result,
   input wire logic        slot_busy,
   input wire logic        beta_meas_req,
   input wire logic        temp_meas_start,
   input wire logic [15:0] slot_ideality,
   input wire logic [3:0]  drive_level,
   input wire logic        temp_wr,
   input wire logic [15:0] temp_wr_data
);
   import beta_cfg_pkg::*;
   // Which front-end answer the slot waits for; answers at other times are ignored.
   logic bw_q, bw_d, cw_q, cw_d;
   always_comb
   begin
      bw_d = beta_meas_req | (bw_q & ~beta_done & ~diode_fault_detect & slot_busy);
      cw_d = temp_meas_start | (cw_q & ~conv_done & ~diode_fault_detect & slot_busy);
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         {bw_q, cw_q} <= 2'b00;
      else
         {bw_q, cw_q} <= {bw_d, cw_d};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_accept;
      slot_start && !slot_busy && slot_chan != 2'h0;
   endsequence
   sequence s_beta_ok;
      bw_q && beta_done && beta_code <= BETA_LAST_VALID_CODE && !diode_fault_detect;
   endsequence
   sequence s_beta_low;
      bw_q && beta_done && beta_code > BETA_LAST_VALID_CODE;
   endsequence
   a_slot_accept: assert property (s_accept |=> slot_busy && (beta_meas_req != temp_meas_start))
      else $error("slot start not answered");
   a_direct_drive: assert property (s_accept ##1 temp_meas_start |-> drive_level == DRIVE_NOMINAL)
      else $error("drive not nominal without beta");
   a_beta_drive: assert property (s_beta_ok |=> temp_meas_start && drive_level == $past(beta_code))
      else $error("drive not set from beta");
   a_low_beta_skip: assert property (s_beta_low |=> temp_wr && temp_wr_data == TEMP_FAULT_VALUE
      && !slot_busy && !temp_meas_start)
      else $error("low beta not skipped");
   a_fault_zero: assert property (slot_busy && diode_fault_detect |=> temp_wr && temp_wr_data == 16'h0000)
      else $error("fault result not zero");
   a_conv_store: assert property (cw_q && conv_done && !diode_fault_detect
      |=> temp_wr && temp_wr_data == $past(conv_result) && !slot_busy)
      else $error("result not stored");
   a_ideality_held: assert property (slot_busy && $past(slot_busy) |-> $stable(slot_ideality))
      else $error("ideality changed in slot");
   a_meas_order: assert property (bw_q |-> !temp_meas_start)
      else $error("measurement before beta");
   a_single_write: assert property (temp_wr |=> !temp_wr)
      else $error("double result write");
endmodule // slot_checker

bind remote_diode_ideality_beta_config slot_checker slot_checker_inst (.clk, .rst_b, .slot_start, .slot_chan,
   .diode_fault_detect, .beta_done, .beta_code, .conv_done, .conv_result, .slot_busy, .beta_meas_req,
   .temp_meas_start, .slot_ideality, .drive_level, .temp_wr, .temp_wr_data);

// ===== test/diode_front_end.sv
`timescale 1ns/100ps
module diode_front_end (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        beta_meas_req,
   input wire logic        temp_meas_start,
   input wire logic        fault_on,
   input wire logic [3:0]  code_set,
   input wire logic [15:0] res_set,
   input wire logic [9:0]  dly,
   output logic            diode_fault_detect,
   output logic            beta_done,
   output logic [3:0]      beta_code,
   output logic            conv_done,
   output logic [15:0]     conv_result
);
   logic [1:0] mode_q;
   logic [9:0] cnt_q;
   // Result lines toggle outside their strobe, so a stale value can never pass for a fresh one.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         {mode_q, cnt_q} <= 12'h000;
         {beta_done, conv_done, diode_fault_detect} <= 3'b000;
         {beta_code, conv_result} <= 20'h5A5A5;
      end
      else
      begin
         {beta_done, conv_done, diode_fault_detect} <= 3'b000;
         beta_code <= ~beta_code;
         conv_result <= ~conv_result;
         if (beta_meas_req || temp_meas_start)
         begin
            mode_q <= beta_meas_req ? 2'h1 : 2'h2;
            cnt_q <= dly;
         end
         else if (mode_q != 2'h0 && cnt_q != 10'h000)
            cnt_q <= cnt_q - 10'h001;
         else if (mode_q != 2'h0)
         begin
            mode_q <= 2'h0;
            if (fault_on)
               diode_fault_detect <= 1'b1;
            else if (mode_q == 2'h1)
               {beta_done, beta_code} <= {1'b1, code_set};
            else
               {conv_done, conv_result} <= {1'b1, res_set};
         end
      end
   end
endmodule // diode_front_end

// ===== test/tb.sv
`timescale 1ns/100ps
module tb;
   import beta_cfg_pkg::*;
   typedef struct packed {
      logic [1:0] ch; logic [7:0] ben; logic [7:0] cen; logic [7:0] code; logic [3:0] bc; logic df;
      logic [15:0] res; logic [9:0] dly; logic [15:0] eid; logic [15:0] edat; logic ef;
   } row_t;
   row_t rows [7] = '{
      '{2'h2, 8'h04, 8'h04, 8'h10, 4'h3, 1'b0, 16'hABCD, 10'h005, 16'h2710, 16'hABCD, 1'b0},
      '{2'h3, 8'h08, 8'h02, 8'h3F, 4'h9, 1'b0, 16'h5A5A, 10'h000, 16'h2760, 16'h5A5A, 1'b0},
      '{2'h3, 8'h08, 8'h08, 8'h3F, 4'hA, 1'b0, 16'h5A5A, 10'h001, 16'h28E6, 16'h0000, 1'b1},
      '{2'h1, 8'h02, 8'h02, 8'h00, 4'hF, 1'b0, 16'h1111, 10'h002, 16'h2670, 16'h0000, 1'b1},
      '{2'h1, 8'h00, 8'h02, 8'h18, 4'h0, 1'b0, 16'h1111, 10'h003, 16'h2760, 16'h1111, 1'b0},
      '{2'h2, 8'h00, 8'h00, 8'h18, 4'h0, 1'b1, 16'h2222, 10'h002, 16'h2760, 16'h0000, 1'b1},
      '{2'h2, 8'h00, 8'h00, 8'h18, 4'h0, 1'b1, 16'h2222, 10'h002, 16'h2760, 16'h0000, 1'b1}};
   logic        clk = 1'b0, rst_b = 1'b0, scl = 1'b1, sda_m = 1'b0, slot_start = 1'b0, fault_on = 1'b0;
   logic [1:0]  slot_chan = 2'h0, ch_v;
   logic [3:0]  code_set = 4'h0, beta_code, drive_level, drv_v;
   logic [9:0]  dly = 10'h000;
   logic [15:0] res_set = 16'h0000, conv_result, slot_ideality, temp_wr_data, id_v, dat_v;
   logic        sda_out, sda_oe, diode_fault_detect, beta_done, conv_done, slot_busy, beta_meas_req;
   logic        temp_meas_start, temp_wr, sda_line;
   logic [1:0]  temp_wr_chan;
   logic [7:0]  v;
   logic [8:0]  q;
   int          n_checks = 0, bad_count = 0;
   // Open-drain wire with a pull-up: low while either party pulls it.
   assign sda_line = (sda_m || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
   always #20 clk = ~clk;
   remote_diode_ideality_beta_config remote_diode_ideality_beta_config_inst (.clk, .rst_b, .scl_in(scl),
      .sda_in(sda_line), .sda_out, .sda_oe, .slot_start, .slot_chan, .diode_fault_detect, .beta_done,
      .beta_code, .conv_done, .conv_result, .slot_busy, .beta_meas_req, .temp_meas_start, .slot_ideality,
      .drive_level, .temp_wr, .temp_wr_chan, .temp_wr_data);
   diode_front_end diode_front_end_inst (.clk, .rst_b, .beta_meas_req, .temp_meas_start, .fault_on,
      .code_set, .res_set, .dly, .diode_fault_detect, .beta_done, .beta_code, .conv_done, .conv_result);
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask
   task hp;
      repeat (5) @(posedge clk);
   endtask
   task start;
      sda_m <= 1'b0;
      hp;
      scl <= 1'b1;
      hp;
      sda_m <= 1'b1;
      hp;
      scl <= 1'b0;
      hp;
   endtask
   // Nine clocks per byte, MSB first; a one in d releases the line so the device can answer.
   task bit9(input logic [8:0] d);
      for (int i = 8; i >= 0; i--)
      begin
         sda_m <= !d[i];
         hp;
         scl <= 1'b1;
         hp;
         q[i] = sda_line;
         scl <= 1'b0;
         hp;
      end
   endtask
   task stop;
      sda_m <= 1'b1;
      hp;
      scl <= 1'b1;
      hp;
      sda_m <= 1'b0;
      hp;
   endtask
   task reg_wr(input logic [7:0] ofs, input logic [7:0] d);
      start;
      bit9({SLAVE_ADDR_DEFAULT, 2'b01});
      bit9({ofs, 1'b1});
      bit9({d, 1'b1});
      stop;
   endtask
   task rdc(input logic [7:0] ofs, input logic [7:0] e, input string m);
      start;
      bit9({SLAVE_ADDR_DEFAULT, 2'b01});
      bit9({ofs, 1'b1});
      start;
      bit9({SLAVE_ADDR_DEFAULT, 2'b11});
      bit9(9'h1FF);
      v = q[8:1];
      stop;
      chk(v === e, m);
   endtask
   task slot(input logic [1:0] ch);
      int i;
      slot_start <= 1'b1;
      slot_chan <= ch;
      @(posedge clk);
      slot_start <= 1'b0;
      i = 0;
      while (temp_wr !== 1'b1 && i < 2000)
      begin
         @(posedge clk);
         #1;
         i++;
      end
      {id_v, dat_v, ch_v, drv_v} = {slot_ideality, temp_wr_data, temp_wr_chan, drive_level};
      @(posedge clk);
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      rdc(IDEALITY_FACTOR_SELECT_OFS, 8'h18, "ideality code reset");
      rdc(IDEALITY_CUSTOM_ENABLE_OFS, 8'h00, "custom enable reset");
      rdc(BETA_COMP_ENABLE_OFS, 8'h00, "beta enable reset");
      for (int c = 0; c < 3; c++)
         rdc(BETA_RESULT_CH1_OFS + 8'(c), 8'h00, "beta result reset");
      reg_wr(IDEALITY_CUSTOM_ENABLE_OFS, 8'hFF);
      rdc(IDEALITY_CUSTOM_ENABLE_OFS, 8'h0E, "custom enable reserved");
      reg_wr(BETA_COMP_ENABLE_OFS, 8'hFF);
      rdc(BETA_COMP_ENABLE_OFS, 8'h0E, "beta enable reserved");
      reg_wr(BETA_RESULT_CH1_OFS, 8'hFF);
      rdc(BETA_RESULT_CH1_OFS, 8'h00, "beta result read only");
      rdc(8'h40, 8'h00, "unmapped read");
      foreach (rows[k])
      begin
         reg_wr(IDEALITY_FACTOR_SELECT_OFS, rows[k].code);
         reg_wr(IDEALITY_CUSTOM_ENABLE_OFS, rows[k].cen);
         reg_wr(BETA_COMP_ENABLE_OFS, rows[k].ben);
         {code_set, res_set, dly, fault_on} <= {rows[k].bc, rows[k].res, rows[k].dly, rows[k].df};
         slot(rows[k].ch);
         chk(id_v === rows[k].eid, "slot ideality");
         chk(dat_v === rows[k].edat && ch_v === rows[k].ch, "stored temperature");
         if (rows[k].bc <= 4'h9)
            chk(drv_v === (rows[k].ben[rows[k].ch] ? rows[k].bc : 4'h0), "drive level");
         rdc(DIODE_FAULT_STATUS_OFS, rows[k].ef ? 8'h01 << rows[k].ch : 8'h00, "fault status");
         rdc(DIODE_FAULT_STATUS_OFS, 8'h00, "fault status cleared");
         if (rows[k].ben[rows[k].ch])
            rdc(BETA_COMP_ENABLE_OFS + {6'h0, rows[k].ch}, {4'h0, rows[k].bc}, "beta result");
      end
      reg_wr(IDEALITY_FACTOR_SELECT_OFS, 8'h20);
      {code_set, res_set, dly, fault_on} <= {4'h7, 16'h3C3C, 10'h3FF, 1'b0};
      fork
         slot(2'h2);
         begin
            repeat (3) @(posedge clk);
            reg_wr(IDEALITY_CUSTOM_ENABLE_OFS, 8'h04);
            reg_wr(BETA_COMP_ENABLE_OFS, 8'h04);
         end
      join
      chk(id_v === IDEALITY_DEFAULT && drv_v === 4'h0 && dat_v === 16'h3C3C, "mid slot change");
      dly <= 10'h002;
      slot(2'h2);
      chk(id_v === 16'h27B0 && drv_v === 4'h7 && dat_v === 16'h3C3C, "next slot settings");
      // A reset in mid-run must bring back the power-on settings.
      rst_b <= 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      rdc(IDEALITY_FACTOR_SELECT_OFS, 8'h18, "ideality code after reset");
      rdc(BETA_COMP_ENABLE_OFS, 8'h00, "beta enable after reset");
      rdc(IDEALITY_CUSTOM_ENABLE_OFS, 8'h00, "custom enable after reset");
      summarize;
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      bad_count++;
      summarize;
   end
endmodule // tb
